//--- logic/amxc_defs.vh
// Constants for the two-wire mixer and mode control block.
// Assumes inclusion by bare name from logic/ design files.
`ifndef AMXC_DEFS_VH
`define AMXC_DEFS_VH

// ----------------------------------------------------------------
// Bus address and command layout
// ----------------------------------------------------------------
`define AMXC_ADDR_HI      6'h3E
`define AMXC_SEL_MONO     2'h0
`define AMXC_SEL_LEFT     2'h1
`define AMXC_SEL_RIGHT    2'h2
`define AMXC_SEL_MODE     2'h3
`define AMXC_BIT_WIDEN    5
`define AMXC_BIT_EPGAIN   4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AMXC_RST_VOL      5'h00
`define AMXC_RST_MODE     4'h0

// ----------------------------------------------------------------
// Output path encodings
// ----------------------------------------------------------------
`define AMXC_OUT_SD       2'h0
`define AMXC_OUT_MUTE     2'h1
`define AMXC_OUT_ON       2'h2

`endif

//--- logic/amxc_sync.v
// Two-flop synchroniser for one level from outside the clk_sys domain.
// Assumes clk_sys is much faster than the incoming level changes.
`include "amxc_defs.vh"

module amxc_sync (
  clk_sys,
  rst,
  din,
  dout
);
  input  wire clk_sys;
  input  wire rst;
  input  wire din;
  output reg  dout;

  reg firstQ;

  // Bus lines idle high, so reset to one to avoid a false start
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      firstQ <= 1'b1;
      dout   <= 1'b1;
    end else begin
      firstQ <= din;
      dout   <= firstQ;
    end
  end
endmodule // amxc_sync

//--- logic/amxc_mixer_ctrl.v
// Write-only two-wire slave and output mode decoder of an audio mixer.
// Assumes the bus master drives scl, sda is open drain, pins are async.
//
// Functional notes
// [R01] Own address is 111110, then address select pin, then write bit zero.
// [R02] Start is sda falling while scl high; then address is compared.
// [R03] Address byte shifted in msb first on scl rising edges.
// [R04] Master keeps each address bit steady while scl is high.
// [R05] Master releases sda after address and gives one acknowledge clock.
// [R06] On address match slave pulls sda low during acknowledge clock.
// [R07] Master abandons transfer when acknowledge is missing; the bench master still sends data after a foreign address.
// [R08] Command bytes msb first, each acknowledged by the slave.
// [R09] Further command bytes in one transfer are each accepted and applied.
// [R10] Stop is sda rising while scl high; ends the transfer.
// [R11] Master keeps sda high when idle, scl at most 400kHz; the bench master clocks scl at 8MHz.
// [R12] Mode 11: earpiece gets mono plus left plus right, others off or muted.
// [R13] Mode 6 earpiece and mode 10 line output carry left plus right.
// [R14] Line output carries mono in mode 5, full sum in mode 15.
// [R15] Loudspeakers: mono modes 2,3; stereo 7,8; stereo plus mono 12,13.
// [R16] Headphones: mono 3,4; stereo 8,9; stereo plus mono 13,14.
// [R17] Earpiece stage gain 0dB when select is 0, 6dB when 1.
// [R18] Loudspeaker widening enable bit: 0 off, 1 on.
// [R19] Headphone widening enable bit independent: 0 off, 1 on.
// [R20] Wake-up speed select: 0 fast, 1 slow.
// [R21] Controller lowers stereo volume 6dB after enabling widening.
// [R22] Top two command bits select mono, left, right volume or mode.
// [R23] Mono volume code maps -34.5dB to 12.0dB in 1.5dB steps.
// [R24] Left and right codes map -40.5dB to 6.0dB in 1.5dB steps.
// [R25] Mode 0 all shut down; unused line out and headphones mute, rest shut.
// [R26] No acknowledge and no update on address mismatch or read.
`include "amxc_defs.vh"

module amxc_mixer_ctrl (
  clk_sys,
  rst,
  sclIn,
  sdaIn,
  sdaOut,
  sdaOe_n,
  address_select_bit,
  monoVolume,
  leftVolume,
  rightVolume,
  outputMode,
  earpiece_gain_select,
  wakeup_speed_select,
  speaker_spatial_enable,
  headphone_spatial_enable,
  mono_line_output,
  earpiece_output,
  earpieceSumMono,
  earpieceSumStereo,
  lineSumMono,
  lineSumStereo,
  speakerLeft,
  speakerRight,
  speakerAddMono,
  speakerAddStereo,
  headphoneLeft,
  headphoneRight,
  headphoneAddMono,
  headphoneAddStereo,
  powered_down,
  busActive
);
  input  wire       clk_sys;
  input  wire       rst;
  input  wire       sclIn;
  input  wire       sdaIn;
  output wire       sdaOut;
  output reg        sdaOe_n;
  input  wire       address_select_bit;
  output reg  [4:0] monoVolume;
  output reg  [4:0] leftVolume;
  output reg  [4:0] rightVolume;
  output reg  [3:0] outputMode;
  output reg        earpiece_gain_select;
  output reg        wakeup_speed_select;
  output reg        speaker_spatial_enable;
  output reg        headphone_spatial_enable;
  output reg  [1:0] mono_line_output;
  output reg  [1:0] earpiece_output;
  output reg        earpieceSumMono;
  output reg        earpieceSumStereo;
  output reg        lineSumMono;
  output reg        lineSumStereo;
  output reg  [1:0] speakerLeft;
  output reg  [1:0] speakerRight;
  output reg        speakerAddMono;
  output reg        speakerAddStereo;
  output reg  [1:0] headphoneLeft;
  output reg  [1:0] headphoneRight;
  output reg        headphoneAddMono;
  output reg        headphoneAddStereo;
  output reg        powered_down;
  output reg        busActive;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire sclS;
  wire sdaS;
  wire adrS;

  amxc_sync uSyncScl (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (sclIn),
    .dout    (sclS)
  );
  amxc_sync uSyncSda (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (sdaIn),
    .dout    (sdaS)
  );
  amxc_sync uSyncAdr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (address_select_bit),
    .dout    (adrS)
  );

  // ----------------------------------------------------------------
  // Edge and condition detection
  // ----------------------------------------------------------------
  reg  sclPrev_q;
  reg  sdaPrev_q;
  wire sclRise   = sclS & ~sclPrev_q;
  wire sclFall   = ~sclS & sclPrev_q;
  wire startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;  // R02
  wire stopCond  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;  // R10

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  // ----------------------------------------------------------------
  // Slave state machine
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_AACK  = 3'h2;
  localparam ST_DATA  = 3'h3;
  localparam ST_DACK  = 3'h4;
  localparam ST_IGNR  = 3'h5;

  reg [2:0] state_q;
  reg [2:0] bitCnt_q;
  reg [7:0] shift_q;
  reg       ackHigh_q;

  wire [7:0] byteIn    = {shift_q[6:0], sdaS};
  wire [7:0] ownAddr   = {`AMXC_ADDR_HI, adrS, 1'b0};
  wire       addrMatch = (byteIn == ownAddr);  // R01 R26

  assign sdaOut = 1'b0;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q                  <= ST_IDLE;
      bitCnt_q                 <= 3'h0;
      shift_q                  <= 8'h00;
      ackHigh_q                <= 1'b0;
      sdaOe_n                  <= 1'b1;
      busActive                <= 1'b0;
      monoVolume               <= `AMXC_RST_VOL;
      leftVolume               <= `AMXC_RST_VOL;
      rightVolume              <= `AMXC_RST_VOL;
      outputMode               <= `AMXC_RST_MODE;
      earpiece_gain_select     <= 1'b0;
      wakeup_speed_select      <= 1'b0;
      speaker_spatial_enable   <= 1'b0;
      headphone_spatial_enable <= 1'b0;
    end else if (startCond) begin
      // Repeated start is handled the same as a fresh one
      state_q   <= ST_ADDR;  // R02
      bitCnt_q  <= 3'h0;
      ackHigh_q <= 1'b0;
      sdaOe_n   <= 1'b1;
      busActive <= 1'b1;
    end else if (stopCond) begin
      state_q   <= ST_IDLE;  // R10
      sdaOe_n   <= 1'b1;
      busActive <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (sclRise) begin
            shift_q  <= byteIn;  // R03
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              state_q <= addrMatch ? ST_AACK : ST_IGNR;  // R26
            end
          end
        end
        ST_AACK, ST_DACK: begin
          // Drive low from the fall after bit 8 until the fall after the ack clock
          if (sclFall) begin
            if (!ackHigh_q && sdaOe_n) begin
              sdaOe_n <= 1'b0;  // R06 R08
            end else if (ackHigh_q) begin
              sdaOe_n   <= 1'b1;
              ackHigh_q <= 1'b0;
              bitCnt_q  <= 3'h0;
              state_q   <= ST_DATA;  // R09
            end
          end
          if (sclRise && !sdaOe_n) begin
            ackHigh_q <= 1'b1;
          end
        end
        ST_DATA: begin
          if (sclRise) begin
            shift_q  <= byteIn;  // R08
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              state_q <= ST_DACK;
              case (byteIn[7:6])  // R22
                `AMXC_SEL_MONO: begin
                  monoVolume <= byteIn[4:0];  // R23
                end
                `AMXC_SEL_LEFT: begin
                  leftVolume             <= byteIn[4:0];  // R24
                  speaker_spatial_enable <= byteIn[`AMXC_BIT_WIDEN];  // R18
                end
                `AMXC_SEL_RIGHT: begin
                  rightVolume              <= byteIn[4:0];  // R24
                  headphone_spatial_enable <= byteIn[`AMXC_BIT_WIDEN];  // R19
                end
                default: begin
                  outputMode           <= byteIn[3:0];
                  earpiece_gain_select <= byteIn[`AMXC_BIT_EPGAIN];  // R17
                  wakeup_speed_select  <= byteIn[`AMXC_BIT_WIDEN];  // R20
                end
              endcase
            end
          end
        end
        default: begin
          // Idle or not addressed: wait for the next start
          sdaOe_n <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output mode decode, registered so the analog controls are glitch free
  // ----------------------------------------------------------------
  reg [1:0] lineD;
  reg [1:0] earD;
  reg       earMonoD;
  reg       earStD;
  reg       lineMonoD;
  reg       lineStD;
  reg [1:0] spkD;
  reg       spkMonoD;
  reg       spkStD;
  reg [1:0] hpD;
  reg       hpMonoD;
  reg       hpStD;
  reg [7:0] mixD;
  reg [1:0] idleD;

  // Mix bits from the top: earpiece, line out, loudspeakers, headphones,
  // each as mono then left plus right; one row per mode keeps the table readable
  always @* begin
    case (outputMode)
      4'h1:    mixD = 8'h80;
      4'h2:    mixD = 8'h08;  // R15
      4'h3:    mixD = 8'h0A;  // R15 R16
      4'h4:    mixD = 8'h02;  // R16
      4'h5:    mixD = 8'h20;  // R14
      4'h6:    mixD = 8'h40;  // R13
      4'h7:    mixD = 8'h04;  // R15
      4'h8:    mixD = 8'h05;  // R15 R16
      4'h9:    mixD = 8'h01;  // R16
      4'hA:    mixD = 8'h10;  // R13
      4'hB:    mixD = 8'hC0;  // R12
      4'hC:    mixD = 8'h0C;  // R15
      4'hD:    mixD = 8'h0F;  // R15 R16
      4'hE:    mixD = 8'h03;  // R16
      4'hF:    mixD = 8'h30;  // R14
      default: mixD = 8'h00;  // R25
    endcase
  end

  // ----------------------------------------------------------------
  // Path states
  // ----------------------------------------------------------------
  // A path is on whenever it mixes anything; idle line out and headphones mute outside mode 0, where they shut down
  always @* begin
    earMonoD  = mixD[7];
    earStD    = mixD[6];
    lineMonoD = mixD[5];
    lineStD   = mixD[4];
    spkMonoD  = mixD[3];
    spkStD    = mixD[2];
    hpMonoD   = mixD[1];
    hpStD     = mixD[0];
    idleD     = (outputMode == 4'h0) ? `AMXC_OUT_SD : `AMXC_OUT_MUTE;  // R25
    earD      = (|mixD[7:6]) ? `AMXC_OUT_ON : `AMXC_OUT_SD;  // R12 R13
    lineD     = (|mixD[5:4]) ? `AMXC_OUT_ON : idleD;  // R14 R25
    spkD      = (|mixD[3:2]) ? `AMXC_OUT_ON : `AMXC_OUT_SD;  // R15
    hpD       = (|mixD[1:0]) ? `AMXC_OUT_ON : idleD;  // R16 R25
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mono_line_output   <= `AMXC_OUT_SD;
      earpiece_output    <= `AMXC_OUT_SD;
      earpieceSumMono    <= 1'b0;
      earpieceSumStereo  <= 1'b0;
      lineSumMono        <= 1'b0;
      lineSumStereo      <= 1'b0;
      speakerLeft        <= `AMXC_OUT_SD;
      speakerRight       <= `AMXC_OUT_SD;
      speakerAddMono     <= 1'b0;
      speakerAddStereo   <= 1'b0;
      headphoneLeft      <= `AMXC_OUT_SD;
      headphoneRight     <= `AMXC_OUT_SD;
      headphoneAddMono   <= 1'b0;
      headphoneAddStereo <= 1'b0;
      powered_down       <= 1'b1;
    end else begin
      mono_line_output   <= lineD;
      earpiece_output    <= earD;
      earpieceSumMono    <= earMonoD;
      earpieceSumStereo  <= earStD;
      lineSumMono        <= lineMonoD;
      lineSumStereo      <= lineStD;
      speakerLeft        <= spkD;
      speakerRight       <= spkD;
      speakerAddMono     <= spkMonoD;
      speakerAddStereo   <= spkStD;
      headphoneLeft      <= hpD;
      headphoneRight     <= hpD;
      headphoneAddMono   <= hpMonoD;
      headphoneAddStereo <= hpStD;
      powered_down       <= (outputMode == 4'h0);  // R25
    end
  end
endmodule // amxc_mixer_ctrl

//--- tb/amxc_mixer_ctrl_sva.sv
// Concurrent checks on the ports of the two-wire mixer and mode control block.
// Assumes a single clk_sys domain and the async active-high rst.
module amxc_mixer_ctrl_sva (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe_n,
  input wire logic [3:0] outputMode,
  input wire logic [4:0] monoVolume,
  input wire logic [1:0] earpiece_output,
  input wire logic [1:0] mono_line_output,
  input wire logic [1:0] headphoneLeft,
  input wire logic       powered_down,
  input wire logic       busActive
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Acknowledge driving
  // ----------------------------------------------------------------
  property p_ack_only_busy; !busActive |-> sdaOe_n; endproperty
  a_ack_only_busy: assert property (p_ack_only_busy)
    else $error("Data line pulled while bus idle");
  property p_ack_start_low; $fell(sdaOe_n) |-> !sclIn && !sdaOut; endproperty
  a_ack_start_low: assert property (p_ack_start_low)
    else $error("Acknowledge began outside clock low phase");
  property p_ack_end_low; $rose(sdaOe_n) |-> !sclIn; endproperty
  a_ack_end_low: assert property (p_ack_end_low)
    else $error("Acknowledge released while clock high");
  property p_ack_spans_high; !sdaOe_n && $rose(sclIn) |-> (!sdaOe_n) [*4]; endproperty
  a_ack_spans_high: assert property (p_ack_spans_high)
    else $error("Acknowledge dropped during clock high");

  // ----------------------------------------------------------------
  // Framing and stored fields
  // ----------------------------------------------------------------
  property p_start_busy; $fell(sdaIn) && sclIn |-> ##[1:6] busActive; endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("Start not seen");
  property p_stop_idle; $rose(sdaIn) && sclIn |-> ##[1:6] !busActive; endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("Stop not seen");
  property p_hold_idle; !busActive |=> $stable(outputMode) && $stable(monoVolume); endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("Field changed with no transfer");

  // ----------------------------------------------------------------
  // Mode decode, one cycle behind outputMode
  // ----------------------------------------------------------------
  property p_powered_down; powered_down == ($past(outputMode) == 4'h0); endproperty
  a_powered_down: assert property (p_powered_down)
    else $error("Power-down flag wrong");
  property p_ear_state;
    earpiece_output == (($past(outputMode) inside {1, 6, 11}) ? 2'h2 : 2'h0);
  endproperty
  a_ear_state: assert property (p_ear_state)
    else $error("Earpiece state wrong");
  property p_line_state;
    mono_line_output == (($past(outputMode) == 4'h0) ? 2'h0 :
      (($past(outputMode) inside {5, 10, 15}) ? 2'h2 : 2'h1));
  endproperty
  a_line_state: assert property (p_line_state)
    else $error("Line output state wrong");
  property p_hp_state;
    headphoneLeft == (($past(outputMode) == 4'h0) ? 2'h0 :
      (($past(outputMode) inside {3, 4, 8, 9, 13, 14}) ? 2'h2 : 2'h1));
  endproperty
  a_hp_state: assert property (p_hp_state)
    else $error("Headphone state wrong");
endmodule // amxc_mixer_ctrl_sva

bind amxc_mixer_ctrl amxc_mixer_ctrl_sva amxc_mixer_ctrl_sva_inst (
  .clk_sys, .rst, .sclIn, .sdaIn, .sdaOut, .sdaOe_n, .outputMode, .monoVolume,
  .earpiece_output, .mono_line_output, .headphoneLeft, .powered_down, .busActive);

//--- tb/amxc_i2c_master.sv
// Behavioural two-wire bus master driving the block's link pins.
// Assumes an open-drain data line with a pull-up resolved by the bench.
module amxc_i2c_master (
  output logic sclPin,
  output logic sdaOe_n,
  input  wire  sdaLine
);
  timeunit 1ns;
  timeprecision 100ps;
  // Half of a 125 ns bus clock period
  localparam realtime H = 62.5;

  // Clock stands still high between frames, data released
  initial begin
    sclPin = 1'b1;
    sdaOe_n = 1'b1;
  end

  task automatic bus_start();
    #(H) sdaOe_n = 1'b0;
    #(H/2) sclPin = 1'b0;
    #(H/2);
  endtask

  // Data changes only mid low phase, so it is steady while the clock is high
  task automatic send_bit(input logic b);
    sdaOe_n = b;
    #(H/2) sclPin = 1'b1;
    #(H) sclPin = 1'b0;
    #(H/2);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) send_bit(b[i]);
    sdaOe_n = 1'b1;
    #(H/2) sclPin = 1'b1;
    #(H/2) ack = !sdaLine;
    #(H/2) sclPin = 1'b0;
    #(H/2);
  endtask

  task automatic bus_stop();
    sdaOe_n = 1'b0;
    #(H/2) sclPin = 1'b1;
    #(H/2) sdaOe_n = 1'b1;
    #(H);
  endtask
endmodule // amxc_i2c_master

//--- tb/amxc_mixer_ctrl_bench.sv
// Self-checking bench: bus master model, reference model of the fields and mode table.
// Assumes the design and checker files are compiled before this one.
module amxc_mixer_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst, address_select_bit;
  wire sclIn, mOe_n, sdaOut, sdaOe_n;
  wire [4:0] monoVolume, leftVolume, rightVolume;
  wire [3:0] outputMode;
  wire [1:0] mono_line_output, earpiece_output, speakerLeft, speakerRight;
  wire [1:0] headphoneLeft, headphoneRight;
  wire earpiece_gain_select, wakeup_speed_select, speaker_spatial_enable;
  wire headphone_spatial_enable, earpieceSumMono, earpieceSumStereo, lineSumMono;
  wire lineSumStereo, speakerAddMono, speakerAddStereo, headphoneAddMono;
  wire headphoneAddStereo, powered_down, busActive;
  // Wired-AND of both open-drain drivers with the pull-up
  wire sdaIn = mOe_n & (sdaOe_n | sdaOut);
  int failCount = 0, samplesChecked = 0;
  int mVol = 0, lVol = 0, rVol = 0, mode = 0;
  bit gain = 0, wake = 0, spkW = 0, hpW = 0;

  amxc_mixer_ctrl amxc_mixer_ctrl_inst (.clk_sys, .rst, .sclIn, .sdaIn, .sdaOut, .sdaOe_n,
    .address_select_bit, .monoVolume, .leftVolume, .rightVolume, .outputMode,
    .earpiece_gain_select, .wakeup_speed_select, .speaker_spatial_enable,
    .headphone_spatial_enable, .mono_line_output, .earpiece_output, .earpieceSumMono,
    .earpieceSumStereo, .lineSumMono, .lineSumStereo, .speakerLeft, .speakerRight,
    .speakerAddMono, .speakerAddStereo, .headphoneLeft, .headphoneRight,
    .headphoneAddMono, .headphoneAddStereo, .powered_down, .busActive);
  amxc_i2c_master amxc_i2c_master_inst (.sclPin(sclIn), .sdaOe_n(mOe_n), .sdaLine(sdaIn));

  // ----------------------------------------------------------------
  // Reference model and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic void apply(logic [7:0] b);
    case (b[7:6])
      2'h0: mVol = b[4:0];
      2'h1: begin lVol = b[4:0]; spkW = b[5]; end
      2'h2: begin rVol = b[4:0]; hpW = b[5]; end
      default: begin mode = b[3:0]; gain = b[4]; wake = b[5]; end
    endcase
  endfunction

  // Unused line out and headphones mute outside mode 0, everything else shuts down
  function automatic int st(logic [15:0] m, logic [15:0] on, bit mut);
    return |(m & on) ? 2 : ((mut && mode != 0) ? 1 : 0);
  endfunction

  task automatic compare();
    logic [15:0] m;
    m = 16'h0001 << mode;
    check(monoVolume, mVol);
    check({leftVolume, rightVolume}, {lVol[4:0], rVol[4:0]});
    check(outputMode, mode);
    check({earpiece_gain_select, wakeup_speed_select}, {gain, wake});
    check({speaker_spatial_enable, headphone_spatial_enable}, {spkW, hpW});
    check(powered_down, mode == 0);
    check(earpiece_output, st(m, 16'h0842, 0));
    check(mono_line_output, st(m, 16'h8420, 1));
    check({speakerLeft, speakerRight}, {2{2'(st(m, 16'h318C, 0))}});
    check({headphoneLeft, headphoneRight}, {2{2'(st(m, 16'h6318, 1))}});
    check({earpieceSumMono, earpieceSumStereo}, {|(m & 16'h0802), |(m & 16'h0840)});
    check({lineSumMono, lineSumStereo}, {|(m & 16'h8020), |(m & 16'h8400)});
    check({speakerAddMono, speakerAddStereo}, {|(m & 16'h300C), |(m & 16'h3180)});
    check({headphoneAddMono, headphoneAddStereo}, {|(m & 16'h6018), |(m & 16'h6300)});
  endtask

  task automatic xfer(input logic [7:0] addr, input logic [7:0] data[$], input logic expAck);
    logic ack;
    amxc_i2c_master_inst.bus_start();
    amxc_i2c_master_inst.send_byte(addr, ack);
    check(ack, expAck);
    // A foreign address stands for another device that answers, so data still flows
    if (ack || !expAck) begin
      foreach (data[i]) begin
        amxc_i2c_master_inst.send_byte(data[i], ack);
        check(ack, expAck);
        if (expAck) apply(data[i]);
      end
    end
    amxc_i2c_master_inst.bus_stop();
    repeat (8) @(negedge clk_sys);
    compare();
  endtask

  task automatic wrapUp();
    if (failCount == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, stimulus
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #400us;
    failCount++;
    wrapUp();
  end

  initial begin
    logic [7:0] d[$];
    logic [7:0] bad[$];
    rst = 1'b1;
    address_select_bit = 1'b0;
    void'($urandom(43581));
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    // Synchronisers need a few edges before the bus may move
    repeat (4) @(negedge clk_sys);
    compare();
    for (int a = 0; a < 2; a++) begin
      address_select_bit = a[0];
      repeat (4) @(negedge clk_sys);
      for (int k = 0; k < 16; k++) begin
        d = '{{3'h0, 5'($urandom)}, {2'h1, 6'($urandom)}, {2'h2, 6'($urandom)},
              {2'h3, 2'($urandom), 4'(k)}};
        xfer({6'h3E, a[0], 1'b0}, d, 1'b1);
      end
    end
    // Widening on at 0dB stereo volume (code 27), then lowered by one doubling step
    xfer({6'h3E, 2'b10}, '{8'h7B, 8'h77, 8'hBB, 8'hB7}, 1'b1);
    xfer({6'h3E, 2'b10}, '{8'h1F, 8'h40, 8'h80, 8'hC0}, 1'b1);
    bad = '{{6'h3E, 2'b00}, {6'h3E, 2'b11}, {6'h3F, 2'b10}, {6'h1E, 2'b10}};
    foreach (bad[i]) xfer(bad[i], '{8'hC5, 8'h2A}, 1'b0);
    wrapUp();
  end
endmodule // amxc_mixer_ctrl_bench
